// >>> twoc_pkg.sv
// Shared constants and types for the timer waveform output control block
package twoc_pkg;
    // Register port widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL_A = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_CMP_A = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_CMP_B = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h5;

    // Field positions
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int MODE_LOW_LSB = 0;
    localparam int MODE_HIGH_BIT = 3;
    localparam int RUN_BIT = 0;
    localparam int OVF_BIT = 0;

    // Writable bits; all others read as zero
    localparam logic [DATA_W-1:0] CTRL_A_MASK = 8'hf3;
    localparam logic [DATA_W-1:0] CTRL_B_MASK = 8'h09;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    // Counter landmarks
    localparam logic [DATA_W-1:0] CNT_MAX = 8'hff;
    localparam logic [DATA_W-1:0] CNT_BOTTOM = 8'h00;

    // Waveform mode codes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_PHASE_FF = 3'h1;
    localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_PHASE_CMP = 3'h5;
    localparam logic [2:0] MODE_FAST_CMP = 3'h7;

    // Output action codes
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // One register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } twoc_bus_req_t;
endpackage

// >>> twoc_wave.sv
// Timer counter with two compare channels and waveform output control
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module twoc_wave (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire twoc_pkg::twoc_bus_req_t bus,
    output logic [twoc_pkg::DATA_W-1:0] rd_data,
    // Waveform pins
    output logic wave_out_a,
    output logic wave_out_b,
    output logic wave_pin_sel_a,
    output logic wave_pin_sel_b
);
    logic [7:0] waveform_control_a;
    logic [7:0] ctrl_reg_b;
    logic [7:0] count;
    logic [7:0] cmp_value_a;
    logic [7:0] cmp_value_b;
    logic overflow_flag;
    logic count_down;
    logic [7:0] next_count;
    logic next_down;
    logic [2:0] wave_mode_sel;
    logic wave_mode_high;
    logic is_fast;
    logic is_phase;
    logic is_pwm;
    logic top_is_cmp;
    logic run;
    logic cnt_wr;
    logic at_top;
    logic at_bottom;
    logic ovf_evt;
    logic [7:0] top;
    logic [7:0] cmp_reg [0:1];
    logic [7:0] cmp_act [0:1];
    logic [7:0] cmp_eff [0:1];
    logic [1:0] act [0:1];
    logic match [0:1];
    logic special [0:1];
    logic wave [0:1];
    logic pin_sel [0:1];

    assign wave_mode_high = ctrl_reg_b[twoc_pkg::MODE_HIGH_BIT];
    assign wave_mode_sel = {wave_mode_high, waveform_control_a[twoc_pkg::MODE_LOW_LSB+:2]};
    assign is_fast = (wave_mode_sel == twoc_pkg::MODE_FAST_FF) ||
                     (wave_mode_sel == twoc_pkg::MODE_FAST_CMP);
    assign is_phase = (wave_mode_sel == twoc_pkg::MODE_PHASE_FF) ||
                      (wave_mode_sel == twoc_pkg::MODE_PHASE_CMP);
    assign is_pwm = is_fast || is_phase;
    assign top_is_cmp = (wave_mode_sel == twoc_pkg::MODE_CLR_MATCH) ||
                        (wave_mode_sel == twoc_pkg::MODE_PHASE_CMP) ||
                        (wave_mode_sel == twoc_pkg::MODE_FAST_CMP);
    assign top = top_is_cmp ? cmp_eff[0] : twoc_pkg::CNT_MAX;
    assign run = ctrl_reg_b[twoc_pkg::RUN_BIT];
    assign cnt_wr = bus.wr && (bus.addr == twoc_pkg::OFS_COUNT);
    assign at_top = (count == top);
    assign at_bottom = (count == twoc_pkg::CNT_BOTTOM);
    assign cmp_reg[0] = cmp_value_a;
    assign cmp_reg[1] = cmp_value_b;

    // Register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            waveform_control_a <= twoc_pkg::REG_RESET;
            ctrl_reg_b <= twoc_pkg::REG_RESET;
            cmp_value_a <= twoc_pkg::REG_RESET;
            cmp_value_b <= twoc_pkg::REG_RESET;
        end else if (bus.wr) begin
            unique case (bus.addr)
                twoc_pkg::OFS_CTRL_A: waveform_control_a <= bus.wdata & twoc_pkg::CTRL_A_MASK;
                twoc_pkg::OFS_CTRL_B: ctrl_reg_b <= bus.wdata & twoc_pkg::CTRL_B_MASK;
                twoc_pkg::OFS_CMP_A: cmp_value_a <= bus.wdata;
                twoc_pkg::OFS_CMP_B: cmp_value_b <= bus.wdata;
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= twoc_pkg::REG_RESET;
        end else if (bus.rd) begin
            unique case (bus.addr)
                twoc_pkg::OFS_CTRL_A: rd_data <= waveform_control_a;
                twoc_pkg::OFS_CTRL_B: rd_data <= ctrl_reg_b;
                twoc_pkg::OFS_COUNT: rd_data <= count;
                twoc_pkg::OFS_CMP_A: rd_data <= cmp_value_a;
                twoc_pkg::OFS_CMP_B: rd_data <= cmp_value_b;
                twoc_pkg::OFS_STATUS: rd_data <= {7'h00, overflow_flag};
                default: rd_data <= twoc_pkg::REG_RESET;
            endcase
        end else begin
            rd_data <= twoc_pkg::REG_RESET;
        end
    end

    // Counting sequence; phase modes turn at TOP and at BOTTOM
    always_comb begin
        next_count = count;
        next_down = count_down;
        if (cnt_wr) begin
            next_count = bus.wdata;
        end else if (run && is_phase) begin
            if (!count_down) begin
                if (at_top) begin
                    next_down = 1'b1;
                    next_count = at_bottom ? count : count - 8'h01;
                end else begin
                    next_count = count + 8'h01;
                end
            end else if (at_bottom) begin
                next_down = 1'b0;
                next_count = at_top ? count : count + 8'h01;
            end else begin
                next_count = count - 8'h01;
            end
        end else if (run) begin
            next_down = 1'b0;
            next_count = at_top ? twoc_pkg::CNT_BOTTOM : count + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= twoc_pkg::CNT_BOTTOM;
            count_down <= 1'b0;
        end else begin
            count <= next_count;
            count_down <= next_down;
        end
    end

    // Overflow: MAX in modes 0,2,3 (and reserved), BOTTOM in phase, TOP in mode 7
    always_comb begin
        if (is_phase) begin
            ovf_evt = at_bottom && count_down;
        end else if (wave_mode_sel == twoc_pkg::MODE_FAST_CMP) begin
            ovf_evt = at_top;
        end else begin
            ovf_evt = (count == twoc_pkg::CNT_MAX);
        end
    end

    // Sticky flag, write one to clear; a new event wins over the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_flag <= 1'b0;
        end else if (run && !cnt_wr && ovf_evt) begin
            overflow_flag <= 1'b1;
        end else if (bus.wr && bus.addr == twoc_pkg::OFS_STATUS && bus.wdata[twoc_pkg::OVF_BIT]) begin
            overflow_flag <= 1'b0;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam int LSB = (i == 0) ? twoc_pkg::ACT_A_LSB : twoc_pkg::ACT_B_LSB;
        logic next_wave;
        logic step;

        assign act[i] = waveform_control_a[LSB+:2];
        // Immediate modes see the written value at once; PWM uses the buffered copy
        assign cmp_eff[i] = is_pwm ? cmp_act[i] : cmp_reg[i];
        assign step = run && !cnt_wr;
        assign match[i] = step && (count == cmp_eff[i]);
        assign special[i] = is_pwm && act[i][1] && (cmp_eff[i] == top);

        // Buffered compare value; loading at the turn avoids glitched pulses
        always_ff @(posedge clk) begin
            if (rst) begin
                cmp_act[i] <= twoc_pkg::REG_RESET;
            end else if (!is_pwm) begin
                cmp_act[i] <= cmp_reg[i];
            end else if (is_phase && at_top && !count_down) begin
                cmp_act[i] <= cmp_reg[i];
            end else if (is_fast && at_bottom) begin
                cmp_act[i] <= cmp_reg[i];
            end
        end

        always_comb begin
            next_wave = wave[i];
            if (act[i] == twoc_pkg::ACT_OFF) begin
                next_wave = wave[i];
            end else if (!is_pwm) begin
                if (match[i]) begin
                    unique case (act[i])
                        twoc_pkg::ACT_TOGGLE: next_wave = !wave[i];
                        twoc_pkg::ACT_CLEAR: next_wave = 1'b0;
                        default: next_wave = 1'b1;
                    endcase
                end
            end else if (act[i] == twoc_pkg::ACT_TOGGLE) begin
                // Channel B leaves the reserved code inert
                if (i == 0 && wave_mode_high && match[i]) begin
                    next_wave = !wave[i];
                end
            end else if (is_fast) begin
                if (step && at_bottom) begin
                    next_wave = !act[i][0];
                end
                if (match[i] && !special[i]) begin
                    next_wave = act[i][0];
                end
            end else begin
                if (match[i] && !special[i]) begin
                    next_wave = count_down ? !act[i][0] : act[i][0];
                end else if (special[i] && step && at_top && !count_down) begin
                    next_wave = !act[i][0];
                end
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                wave[i] <= 1'b0;
                pin_sel[i] <= 1'b0;
            end else begin
                wave[i] <= next_wave;
                // On channel A, PWM action 01 without the mode high bit leaves the pin to the port
                pin_sel[i] <= (act[i] != twoc_pkg::ACT_OFF) &&
                              !(i == 0 && is_pwm && !wave_mode_high &&
                                act[i] == twoc_pkg::ACT_TOGGLE);
            end
        end
    end

    // Pin direction stays with software; only the override is driven here
    assign wave_out_a = wave[0];
    assign wave_out_b = wave[1];
    assign wave_pin_sel_a = pin_sel[0];
    assign wave_pin_sel_b = pin_sel[1];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // All PWM modes have the low mode bit set
    property p_sel_a;
        bus.wr && bus.addr == twoc_pkg::OFS_CTRL_A && bus.wdata[7:6] != 2'b00 &&
            !(bus.wdata[7:6] == twoc_pkg::ACT_TOGGLE &&
              bus.wdata[twoc_pkg::MODE_LOW_LSB] && !wave_mode_high) |=> ##1 wave_pin_sel_a;
    endproperty
    a_sel_a: assert property (p_sel_a) else $error("pin select A not raised");

    property p_sel_b;
        bus.wr && bus.addr == twoc_pkg::OFS_CTRL_A && bus.wdata[5:4] == 2'b00
            ##1 !bus.wr |=> !wave_pin_sel_b;
    endproperty
    a_sel_b: assert property (p_sel_b) else $error("pin select B not dropped");

    property p_toggle_a;
        !is_pwm && act[0] == twoc_pkg::ACT_TOGGLE && match[0] |=> wave_out_a != $past(wave_out_a);
    endproperty
    a_toggle_a: assert property (p_toggle_a) else $error("A did not toggle");

    property p_pwm_off_a;
        is_pwm && !wave_mode_high && act[0] == twoc_pkg::ACT_TOGGLE |=> $stable(wave_out_a);
    endproperty
    a_pwm_off_a: assert property (p_pwm_off_a) else $error("A moved while disconnected");

    property p_pwm_nosel_a;
        is_pwm && !wave_mode_high && act[0] == twoc_pkg::ACT_TOGGLE |=> !wave_pin_sel_a;
    endproperty
    a_pwm_nosel_a: assert property (p_pwm_nosel_a) else $error("A pin taken while disconnected");

    property p_fast_a;
        is_fast && act[0] == twoc_pkg::ACT_CLEAR && run && !cnt_wr && at_bottom &&
            cmp_eff[0] != twoc_pkg::CNT_BOTTOM |=> wave_out_a;
    endproperty
    a_fast_a: assert property (p_fast_a) else $error("A not set at bottom");

    property p_phase_a;
        is_phase && act[0] == twoc_pkg::ACT_CLEAR && match[0] && !special[0] &&
            !count_down |=> !wave_out_a;
    endproperty
    a_phase_a: assert property (p_phase_a) else $error("A not cleared up-counting");

    property p_special_a;
        is_fast && act[0] == twoc_pkg::ACT_SET && special[0] && match[0] &&
            !at_bottom |=> $stable(wave_out_a);
    endproperty
    a_special_a: assert property (p_special_a) else $error("A acted on ignored match");

    property p_clear_b;
        !is_pwm && act[1] == twoc_pkg::ACT_CLEAR && match[1] |=> !wave_out_b;
    endproperty
    a_clear_b: assert property (p_clear_b) else $error("B not cleared");

    property p_resv_b;
        is_pwm && act[1] == twoc_pkg::ACT_TOGGLE |=> $stable(wave_out_b);
    endproperty
    a_resv_b: assert property (p_resv_b) else $error("B moved on reserved action");

    property p_phase_b;
        is_phase && act[1] == twoc_pkg::ACT_SET && match[1] && !special[1] &&
            !count_down |=> wave_out_b;
    endproperty
    a_phase_b: assert property (p_phase_b) else $error("B not set up-counting");

    property p_special_b;
        is_phase && act[1] == twoc_pkg::ACT_CLEAR && special[1] && run && !cnt_wr &&
            at_top && !count_down |=> wave_out_b;
    endproperty
    a_special_b: assert property (p_special_b) else $error("B not set at top");

    property p_resv_rd;
        bus.rd && bus.addr == twoc_pkg::OFS_CTRL_A |=> rd_data[3:2] == 2'b00;
    endproperty
    a_resv_rd: assert property (p_resv_rd) else $error("reserved bits read nonzero");

    property p_ctc_wrap;
        wave_mode_sel == twoc_pkg::MODE_CLR_MATCH && run && !cnt_wr &&
            count == cmp_value_a |=> count == twoc_pkg::CNT_BOTTOM;
    endproperty
    a_ctc_wrap: assert property (p_ctc_wrap) else $error("no wrap at compare A");

    property p_ovf_fast;
        wave_mode_sel == twoc_pkg::MODE_FAST_FF && run && !cnt_wr &&
            count == twoc_pkg::CNT_MAX |=> overflow_flag ##1 (overflow_flag || $past(bus.wr));
    endproperty
    a_ovf_fast: assert property (p_ovf_fast) else $error("overflow flag missed");

    property p_cov_fast;
        is_fast && act[0] == twoc_pkg::ACT_CLEAR && match[0] ##1 wave_out_a == 1'b0;
    endproperty
    c_cov_fast: cover property (p_cov_fast);

    property p_cov_phase_turn;
        is_phase && run && at_top && !count_down ##1 count_down;
    endproperty
    c_cov_phase_turn: cover property (p_cov_phase_turn);

    property p_cov_ovf;
        !overflow_flag ##1 overflow_flag;
    endproperty
    c_cov_ovf: cover property (p_cov_ovf);
endmodule // twoc_wave

// >>> twoc_port_pins.sv
// Port pin model: waveform override, pin direction and pad pull-up
`timescale 1ns/10ps
module twoc_port_pins (
    // From the waveform block
    input wire logic wave_out_a,
    input wire logic wave_out_b,
    input wire logic wave_pin_sel_a,
    input wire logic wave_pin_sel_b,
    // Software port setup
    input wire logic dir_a,
    input wire logic dir_b,
    input wire logic port_a,
    input wire logic port_b,
    // Pad levels
    output logic pin_a,
    output logic pin_b
);
    // An undriven pad floats up to its pull-up, never to a stale level
    assign pin_a = dir_a ? (wave_pin_sel_a ? wave_out_a : port_a) : 1'b1;
    assign pin_b = dir_b ? (wave_pin_sel_b ? wave_out_b : port_b) : 1'b1;
endmodule // twoc_port_pins

// >>> twoc_wave_tb.sv
// Self-checking bench for the timer waveform output control block
`timescale 1ns/10ps
module twoc_wave_tb;
    logic clk;
    logic rst;
    twoc_pkg::twoc_bus_req_t bus;
    logic [7:0] rd_data;
    logic wave_out_a;
    logic wave_out_b;
    logic wave_pin_sel_a;
    logic wave_pin_sel_b;
    logic dir_a;
    logic dir_b;
    logic port_a;
    logic port_b;
    logic pin_a;
    logic pin_b;
    logic [7:0] rv;
    int n_errors;
    int check_count;

    twoc_wave i_twoc_wave (.clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data),
        .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
        .wave_pin_sel_a(wave_pin_sel_a), .wave_pin_sel_b(wave_pin_sel_b));

    twoc_port_pins i_twoc_port_pins (.wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
        .wave_pin_sel_a(wave_pin_sel_a), .wave_pin_sel_b(wave_pin_sel_b),
        .dir_a(dir_a), .dir_b(dir_b), .port_a(port_a), .port_b(port_b),
        .pin_a(pin_a), .pin_b(pin_b));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        d = rd_data;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        rd(a, rv);
        chk("register read", {8'h00, exp}, {8'h00, rv});
    endtask

    // Compares are loaded in normal mode, where they take effect at once
    task automatic cfg(input logic [2:0] m, input logic [1:0] aa, input logic [1:0] ab,
                       input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] cnt);
        wr(twoc_pkg::OFS_CTRL_B, 8'h00);
        wr(twoc_pkg::OFS_CTRL_A, 8'h00);
        wr(twoc_pkg::OFS_COUNT, cnt);
        wr(twoc_pkg::OFS_CMP_A, ca);
        wr(twoc_pkg::OFS_CMP_B, cb);
        wr(twoc_pkg::OFS_STATUS, 8'h01);
        wr(twoc_pkg::OFS_CTRL_A, {aa, ab, 2'b00, m[1:0]});
        wr(twoc_pkg::OFS_CTRL_B, {4'h0, m[2], 3'b001});
    endtask

    // Settle past one period, then count high cycles on each pad
    task automatic scn(input logic [2:0] m, input logic [1:0] aa, input logic [1:0] ab,
                       input logic [7:0] ca, input logic [7:0] cb, input int n,
                       input logic [15:0] ea, input logic [15:0] eb);
        logic [15:0] ha;
        logic [15:0] hb;
        ha = 16'h0000;
        hb = 16'h0000;
        cfg(m, aa, ab, ca, cb, 8'h00);
        repeat (600) @(posedge clk);
        repeat (n) begin
            @(posedge clk);
            #1;
            ha = ha + {15'h0000, pin_a};
            hb = hb + {15'h0000, pin_b};
        end
        chk("high cycles on pin a", ea, ha);
        chk("high cycles on pin b", eb, hb);
    endtask

    task automatic ovf(input logic [2:0] m, input logic [7:0] ca, input logic [7:0] cnt,
                       input int w, input logic e);
        cfg(m, 2'h0, 2'h0, ca, 8'h00, cnt);
        repeat (w) @(posedge clk);
        rd(twoc_pkg::OFS_STATUS, rv);
        chk("overflow flag", {15'h0000, e}, {15'h0000, rv[0]});
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        final_report();
    end

    // Actions: 1 toggle, 2 clear, 3 set
    initial begin
        rst = 1'b1;
        bus = '0;
        dir_a = 1'b1;
        dir_b = 1'b1;
        port_a = 1'b0;
        port_b = 1'b0;
        n_errors = 0;
        check_count = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rchk(a[2:0], twoc_pkg::REG_RESET);
        end
        wr(twoc_pkg::OFS_CTRL_A, 8'hff);
        rchk(twoc_pkg::OFS_CTRL_A, 8'hf3);
        wr(twoc_pkg::OFS_CTRL_B, 8'h08);
        rchk(twoc_pkg::OFS_CTRL_B, 8'h08);
        wr(twoc_pkg::OFS_CTRL_B, 8'hff);
        rchk(twoc_pkg::OFS_CTRL_B, 8'h09);
        wr(twoc_pkg::OFS_CTRL_B, 8'h00);
        wr(twoc_pkg::OFS_COUNT, 8'h5a);
        rchk(twoc_pkg::OFS_COUNT, 8'h5a);
        wr(3'h6, 8'hff);
        rchk(3'h6, 8'h00);
        wr(twoc_pkg::OFS_CTRL_A, 8'h40);
        repeat (2) @(posedge clk);
        #1;
        chk("pin select a", 16'h0001, {15'h0000, wave_pin_sel_a});
        chk("pin select b", 16'h0000, {15'h0000, wave_pin_sel_b});
        wr(twoc_pkg::OFS_CTRL_A, 8'h10);
        repeat (2) @(posedge clk);
        #1;
        chk("pin select a", 16'h0000, {15'h0000, wave_pin_sel_a});
        chk("pin select b", 16'h0001, {15'h0000, wave_pin_sel_b});
        // Wave B sits low here, so a floating pad shows up as high
        @(posedge clk);
        dir_b <= 1'b0;
        @(posedge clk);
        #1;
        chk("pin b with driver off", 16'h0001, {15'h0000, pin_b});
        @(posedge clk);
        dir_b <= 1'b1;
        scn(twoc_pkg::MODE_NORMAL, 2'h1, 2'h1, 8'h20, 8'h60, 512, 256, 256);
        scn(twoc_pkg::MODE_NORMAL, 2'h2, 2'h3, 8'h20, 8'h60, 256, 0, 256);
        scn(twoc_pkg::MODE_NORMAL, 2'h3, 2'h2, 8'h20, 8'h60, 256, 256, 0);
        scn(twoc_pkg::MODE_CLR_MATCH, 2'h1, 2'h1, 8'h1f, 8'h10, 64, 32, 32);
        scn(twoc_pkg::MODE_FAST_FF, 2'h2, 2'h3, 8'h40, 8'hc0, 256, 64, 64);
        scn(twoc_pkg::MODE_FAST_FF, 2'h3, 2'h2, 8'h40, 8'hc0, 256, 192, 192);
        scn(twoc_pkg::MODE_FAST_FF, 2'h2, 2'h2, 8'hff, 8'h10, 256, 256, 16);
        scn(twoc_pkg::MODE_FAST_FF, 2'h3, 2'h3, 8'hff, 8'hff, 256, 0, 0);
        // Reserved B code must hold the low level left by the last run
        scn(twoc_pkg::MODE_FAST_FF, 2'h2, 2'h1, 8'h40, 8'h40, 256, 64, 0);
        scn(twoc_pkg::MODE_FAST_FF, 2'h1, 2'h2, 8'h40, 8'h20, 256, 0, 32);
        chk("pin select a", 16'h0000, {15'h0000, wave_pin_sel_a});
        scn(twoc_pkg::MODE_PHASE_FF, 2'h2, 2'h3, 8'h40, 8'h10, 510, 128, 478);
        scn(twoc_pkg::MODE_PHASE_FF, 2'h3, 2'h2, 8'h40, 8'h10, 510, 382, 32);
        scn(twoc_pkg::MODE_PHASE_FF, 2'h2, 2'h3, 8'hff, 8'h80, 510, 510, 254);
        scn(twoc_pkg::MODE_FAST_CMP, 2'h1, 2'h2, 8'h63, 8'h20, 200, 100, 64);
        scn(twoc_pkg::MODE_FAST_CMP, 2'h2, 2'h3, 8'h63, 8'h63, 100, 100, 0);
        scn(twoc_pkg::MODE_PHASE_CMP, 2'h1, 2'h2, 8'h50, 8'h20, 320, 160, 128);
        scn(twoc_pkg::MODE_PHASE_CMP, 2'h3, 2'h2, 8'h50, 8'h50, 160, 0, 160);
        // Reserved B code with the mode high bit set must not toggle
        scn(twoc_pkg::MODE_PHASE_CMP, 2'h3, 2'h1, 8'h50, 8'h20, 160, 0, 160);
        ovf(twoc_pkg::MODE_NORMAL, 8'h00, 8'hf0, 30, 1'b1);
        wr(twoc_pkg::OFS_STATUS, 8'h01);
        rchk(twoc_pkg::OFS_STATUS, 8'h00);
        ovf(twoc_pkg::MODE_NORMAL, 8'h00, 8'h10, 30, 1'b0);
        ovf(twoc_pkg::MODE_CLR_MATCH, 8'h80, 8'h00, 300, 1'b0);
        ovf(twoc_pkg::MODE_FAST_FF, 8'h00, 8'hf0, 30, 1'b1);
        ovf(twoc_pkg::MODE_FAST_CMP, 8'h80, 8'h70, 30, 1'b1);
        ovf(3'h4, 8'h00, 8'hf0, 30, 1'b1);
        ovf(twoc_pkg::MODE_PHASE_FF, 8'h00, 8'hf0, 20, 1'b0);
        repeat (600) @(posedge clk);
        rchk(twoc_pkg::OFS_STATUS, 8'h01);
        // Reset in mid-run must drop both levels and both pin selects
        cfg(twoc_pkg::MODE_FAST_FF, 2'h2, 2'h2, 8'hff, 8'hff, 8'h00);
        repeat (10) @(posedge clk);
        #1;
        chk("levels before reset", 16'h000f,
            {12'h000, wave_out_a, wave_out_b, wave_pin_sel_a, wave_pin_sel_b});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("levels after reset", 16'h0000,
            {12'h000, wave_out_a, wave_out_b, wave_pin_sel_a, wave_pin_sel_b});
        rchk(twoc_pkg::OFS_COUNT, 8'h00);
        rchk(twoc_pkg::OFS_CTRL_B, 8'h00);
        final_report();
    end
endmodule // twoc_wave_tb
